// file: rtl/drst_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "drst_map.vh"
// Notes on behaviour
// R1: Device self-refreshes while row high, refresh low
// R2: Device self-refresh step every 12-16 us
// R3: Device covers all rows within 2 ms
// R4: Self-refresh needs only refresh pin held low
// R5: Refresh pin pulled up internally when open
// R6: Data held while column strobe stays low
// R7: Hidden refresh: column low, precharge, then refresh
// R8: Row strobe high means standby
// R9: Power-up pause then eight dummy cycles
// R10: Column falls 25-60 ns after row
// R11: Row precharge high at least 90 ns
// R12: Column held until 120 ns after row fall
// R13: Row low 60 ns after column fall
// R14: Row and refresh pin never both active
// R15: Automatic refresh uses internal counter
// R16: Leave self-refresh, wait before next row cycle
module drst_ctrl #(
    parameter PWRUP_CYC = `DRST_PWRUP_CYC,
    parameter SELF_MIN_CYC = `DRST_SELF_MIN_CYC,
    parameter AW = 8
) (
    input wire sys_clk,
    input wire resetn,
    input wire req_valid,
    input wire req_write,
    input wire req_hidden,
    input wire [2*AW-1:0] req_addr,
    input wire req_wdata,
    output wire req_ready,
    input wire refresh_req,
    input wire self_req,
    output wire ready_n_init,
    output reg rd_valid,
    output reg rd_data,
    output reg self_active,
    output reg ras_n,
    output reg cas_n,
    output reg we_n,
    output reg ref_n,
    output reg [AW-1:0] addr,
    output reg din,
    input wire dout
);
    // ============================================================
    // State encoding
    localparam [3:0] S_PWR = 4'h0, S_IDLE = 4'h1, S_RAS = 4'h2,
        S_HOLD = 4'h4, S_PRE = 4'h5, S_AREF = 4'h6, S_SELF = 4'h7, S_SEXIT = 4'h8,
        S_DUMMY = 4'h9;
    localparam CW = `DRST_CNT_W;
    localparam [CW-1:0] RCD_LD = `DRST_RCD_CYC;
    localparam [CW-1:0] CSH_LD = `DRST_CSH_CYC;
    // Row rises the cycle after the count reaches zero, so one cycle less
    localparam [CW-1:0] HOLD_LD = `DRST_RSH_CYC - 1;
    localparam [CW-1:0] RP_LD = `DRST_RP_CYC;
    localparam [CW-1:0] REF_RAS_LD = `DRST_REF_RAS_CYC;

    reg [3:0] st_q;
    reg [3:0] dummy_q;
    reg init_q;
    reg keep_cas_q;
    reg hid_q;
    reg [AW-1:0] col_q;
    reg [31:0] pwr_q;
    reg pwr_done_q;
    reg dout_s1_q, dout_s2_q;
    reg ld;
    reg [CW-1:0] ld_val;
    wire tdone;

    drst_wait #(.W(CW)) u_wait (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(ld),
        .value(ld_val),
        .done(tdone)
    );

    assign req_ready = (st_q == S_IDLE) && init_q && !refresh_req && !self_req;
    assign ready_n_init = !init_q;

    // ============================================================
    // Data pin is asynchronous to sys_clk
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            dout_s1_q <= 1'b0;
            dout_s2_q <= 1'b0;
        end
        else
        begin
            dout_s1_q <= dout;
            dout_s2_q <= dout_s1_q;
        end
    end

    always @*
    begin
        ld = 1'b0;
        ld_val = {CW{1'b0}};
        case (st_q)
            S_IDLE:
            begin
                if (!init_q)
                begin
                    ld = 1'b1;
                    ld_val = CSH_LD; // see R9
                end
                else if (req_valid && req_ready)
                begin
                    ld = 1'b1;
                    ld_val = RCD_LD; // see R10
                end
                else if (self_req && init_q)
                begin
                    ld = 1'b1;
                    ld_val = SELF_MIN_CYC[CW-1:0]; // see R4
                end
                else if (refresh_req && init_q)
                begin
                    ld = 1'b1;
                    ld_val = CSH_LD; // see R15
                end
            end
            S_RAS:
            begin
                if (tdone)
                begin
                    ld = 1'b1;
                    ld_val = HOLD_LD; // see R12 R13
                end
            end
            S_HOLD, S_AREF, S_DUMMY:
            begin
                if (tdone)
                begin
                    ld = 1'b1;
                    ld_val = RP_LD; // see R11
                end
            end
            S_SELF:
            begin
                if (tdone && !self_req)
                begin
                    ld = 1'b1;
                    ld_val = REF_RAS_LD; // see R16
                end
            end
            default:
            begin
                ld = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Power-up pause, see R9
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pwr_q <= 32'h0;
            pwr_done_q <= 1'b0;
        end
        else if (!pwr_done_q)
        begin
            pwr_q <= pwr_q + 32'h1;
            if (pwr_q >= PWRUP_CYC)
                pwr_done_q <= 1'b1;
        end
    end

    // ============================================================
    // Sequencer; row and refresh pin are mutually exclusive
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_q <= S_PWR;
            dummy_q <= 4'h0;
            init_q <= 1'b0;
            keep_cas_q <= 1'b0;
            hid_q <= 1'b0;
            col_q <= {AW{1'b0}};
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            ref_n <= 1'b1;
            addr <= {AW{1'b0}};
            din <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 1'b0;
            self_active <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            case (st_q)
                S_PWR:
                begin
                    // Pause counted in a separate wide counter while the loader repeats the precharge count
                    if (dummy_q == 4'h0)
                        dummy_q <= 4'h1;
                    st_q <= S_DUMMY;
                end
                S_DUMMY:
                begin
                    if (tdone && pwr_done_q && ras_n && ref_n) // see R9
                        st_q <= S_PRE;
                end
                S_IDLE:
                begin
                    if (!init_q)
                    begin
                        ras_n <= 1'b0; // see R9
                        st_q <= S_AREF;
                    end
                    else if (req_valid && req_ready)
                    begin
                        // Release of a held column comes with the next row strobe fall, after precharge, see R7
                        keep_cas_q <= 1'b0;
                        cas_n <= 1'b1;
                        addr <= req_addr[2*AW-1:AW];
                        col_q <= req_addr[AW-1:0];
                        hid_q <= req_hidden && !req_write;
                        ras_n <= 1'b0;
                        we_n <= !req_write;
                        din <= req_wdata;
                        st_q <= S_RAS;
                    end
                    else if (self_req)
                    begin
                        ref_n <= 1'b0; // see R14
                        self_active <= 1'b1;
                        st_q <= S_SELF;
                    end
                    else if (refresh_req)
                    begin
                        ref_n <= 1'b0; // see R15
                        st_q <= S_AREF;
                    end
                end
                S_RAS:
                begin
                    // Column address one cycle ahead of the column strobe
                    addr <= col_q;
                    if (tdone)
                    begin
                        cas_n <= 1'b0; // see R10
                        keep_cas_q <= hid_q;
                        st_q <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    if (tdone)
                    begin
                        ras_n <= 1'b1; // see R13
                        we_n <= 1'b1;
                        rd_valid <= we_n;
                        rd_data <= dout_s2_q;
                        // Column stays low for hidden refresh, see R6
                        if (!keep_cas_q)
                            cas_n <= 1'b1;
                        st_q <= S_PRE;
                    end
                end
                S_AREF:
                begin
                    if (tdone)
                    begin
                        ras_n <= 1'b1;
                        ref_n <= 1'b1;
                        if (!init_q)
                            dummy_q <= dummy_q + 4'h1;
                        st_q <= S_PRE;
                    end
                end
                S_SELF:
                begin
                    if (tdone && !self_req)
                    begin
                        ref_n <= 1'b1; // see R16
                        st_q <= S_SEXIT;
                    end
                end
                S_SEXIT:
                begin
                    if (tdone)
                    begin
                        self_active <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                S_PRE:
                begin
                    if (tdone) // see R11
                    begin
                        if (!init_q && dummy_q > `DRST_DUMMY_CYCLES)
                            init_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default:
                begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // drst_ctrl
`default_nettype wire

// file: rtl/drst_map.vh
`ifndef DRST_MAP_VH
`define DRST_MAP_VH
// Timing figures in ns, cycles derived at 40 MHz (25 ns)
`define DRST_CLK_NS 25
`define DRST_PWRUP_NS 500000
`define DRST_PWRUP_CYC ((`DRST_PWRUP_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_DUMMY_CYCLES 8
`define DRST_RCD_MIN_NS 25
`define DRST_RCD_MAX_NS 60
`define DRST_RCD_CYC ((`DRST_RCD_MIN_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_RP_NS 90
`define DRST_RP_CYC ((`DRST_RP_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_CSH_NS 120
`define DRST_CSH_CYC ((`DRST_CSH_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_RSH_NS 60
`define DRST_RSH_CYC ((`DRST_RSH_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_REF_RAS_NS 310
`define DRST_REF_RAS_CYC ((`DRST_REF_RAS_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_SELF_MIN_NS 8000
`define DRST_SELF_MIN_CYC ((`DRST_SELF_MIN_NS + `DRST_CLK_NS - 1) / `DRST_CLK_NS)
`define DRST_CNT_W 15
`endif

// file: rtl/drst_wait.v
`timescale 1ns/1ps
`default_nettype none
// Loadable down counter; done is high once the load value has elapsed
module drst_wait #(
    parameter W = 15
) (
    input wire sys_clk,
    input wire resetn,
    input wire load,
    input wire [W-1:0] value,
    output wire done
);
    reg [W-1:0] cnt_q;
    always @(posedge sys_clk)
    begin
        if (!resetn)
            cnt_q <= {W{1'b0}};
        else if (load)
            cnt_q <= value;
        else if (cnt_q != {W{1'b0}})
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
    // Done depends on the count alone so a loader that reacts to done forms no loop
    assign done = (cnt_q == {W{1'b0}});
endmodule // drst_wait
`default_nettype wire

// file: testbench/drst_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Strobe timing checker
module drst_ctrl_chk #(
    parameter PWRUP_CYC = 10
) (
    input wire sys_clk,
    input wire resetn,
    input wire ready_n_init,
    input wire self_active,
    input wire ras_n,
    input wire cas_n,
    input wire ref_n
);
    int up_q;
    int ras_age_q;
    int dummy_q;
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            up_q <= 0;
            ras_age_q <= 0;
            dummy_q <= 0;
        end
        else
        begin
            up_q <= up_q + 1;
            ras_age_q <= ras_n ? 0 : ras_age_q + 1;
            dummy_q <= dummy_q + ((!ras_n && ras_age_q == 0) ? 1 : 0);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_pwrup_pause: assert property ($fell(ras_n) |-> up_q >= PWRUP_CYC)
        else $error("row strobe before power-up pause");
    chk_dummy_count: assert property ($fell(ready_n_init) |-> dummy_q >= 8)
        else $error("too few dummy cycles");
    chk_cas_delay: assert property ($fell(cas_n) && !ras_n |-> ras_age_q >= 1 && ras_age_q <= 2)
        else $error("column strobe with row strobe");
    chk_row_precharge: assert property ($rose(ras_n) |-> ras_n [*4])
        else $error("precharge too short");
    chk_cas_hold: assert property ($rose(cas_n) && !$past(ras_n) |-> ras_age_q >= 5)
        else $error("column strobe released early");
    chk_ras_hold: assert property ($fell(cas_n) && !ras_n |-> (!ras_n) [*3])
        else $error("row strobe released early");
    chk_pin_excl: assert property (ras_n || ref_n)
        else $error("row strobe and refresh pin both low");
    chk_self_exit: assert property ($fell(self_active) |-> $past(ref_n, 12) && ras_n)
        else $error("row cycle too soon after self-refresh");
endmodule // drst_ctrl_chk
bind drst_ctrl drst_ctrl_chk #(.PWRUP_CYC(PWRUP_CYC)) i_drst_ctrl_chk (.sys_clk(sys_clk), .resetn(resetn),
    .ready_n_init(ready_n_init), .self_active(self_active), .ras_n(ras_n), .cas_n(cas_n), .ref_n(ref_n));
`default_nettype wire

// file: testbench/drst_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Testbench
module drst_ctrl_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_hidden = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic req_wdata = 1'b0;
    logic refresh_req = 1'b0;
    logic self_req = 1'b0;
    wire req_ready, ready_n_init, rd_valid, rd_data, self_active;
    wire ras_n, cas_n, we_n, ref_n, din, dout;
    wire [7:0] addr;
    wire [6:0] ref_row;
    logic sh [0:65535];
    logic [15:0] al [0:11];
    logic [6:0] r0;
    int err_total = 0;
    int checked = 0;
    int n;
    always #12.5 sys_clk = ~sys_clk;
    drst_ctrl #(.PWRUP_CYC(10), .SELF_MIN_CYC(4), .AW(8)) i_drst_ctrl (.sys_clk(sys_clk), .resetn(resetn),
        .req_valid(req_valid), .req_write(req_write), .req_hidden(req_hidden), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .refresh_req(refresh_req), .self_req(self_req),
        .ready_n_init(ready_n_init), .rd_valid(rd_valid), .rd_data(rd_data), .self_active(self_active),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ref_n(ref_n), .addr(addr), .din(din), .dout(dout));
    drst_dev_model i_drst_dev_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ref_n(ref_n), .addr(addr),
        .din(din), .dout(dout), .ref_row(ref_row));
    function automatic logic exp_bit(input logic [15:0] a);
        return sh[a];
    endfunction
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return req_ready;
            1: return ready_n_init;
            2: return rd_valid;
            3: return ref_n;
            default: return self_active;
        endcase
    endfunction
    // Bounded wait for a settled level after each edge
    task automatic wait_for(input int k, input logic v, input int lim);
        for (n = 0; n < lim && sig(k) !== v; n++)
            @(posedge sys_clk) #1;
        if (n >= lim)
        begin
            chk(1'b0, "wait timed out");
            end_sim();
        end
    endtask
    task automatic op(input logic w, input logic h, input logic [15:0] a, input logic d);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_hidden <= h;
        req_addr <= a;
        req_wdata <= d;
        #1 wait_for(0, 1'b1, 400);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        if (w)
            sh[a] = d;
        else
        begin
            #1 wait_for(2, 1'b1, 40);
            chk(rd_data === exp_bit(a), "read data");
        end
    endtask
    task automatic auto_ref(input logic hid, input logic [15:0] a);
        r0 = ref_row;
        @(posedge sys_clk);
        refresh_req <= 1'b1;
        #1 wait_for(3, 1'b0, 400);
        if (hid)
            chk(cas_n === 1'b0 && dout === exp_bit(a), "output lost in hidden refresh");
        @(posedge sys_clk);
        refresh_req <= 1'b0;
        #1 wait_for(3, 1'b1, 400);
        #1 chk(ref_row === r0 + 7'h01, "refresh row step");
    endtask
    initial
    begin
        void'($urandom(32'h3990));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 wait_for(1, 1'b0, 2000);
        for (int i = 0; i < 12; i++)
        begin
            al[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
            op(1'b1, 1'b0, al[i], 1'($urandom));
        end
        auto_ref(1'b0, 16'h0000);
        op(1'b0, 1'b1, al[1], 1'b0);
        auto_ref(1'b1, al[1]);
        r0 = ref_row;
        @(posedge sys_clk);
        self_req <= 1'b1;
        #1 wait_for(4, 1'b1, 400);
        repeat (1300) @(posedge sys_clk);
        #1 chk(ref_row - r0 >= 7'h02 && ref_row - r0 <= 7'h03, "self-refresh steps");
        @(posedge sys_clk);
        self_req <= 1'b0;
        #1 wait_for(4, 1'b0, 400);
        for (int i = 0; i < 12; i++)
            op(1'b0, 1'b0, al[i], 1'b0);
        end_sim();
    end
endmodule // drst_ctrl_tb
`default_nettype wire

// file: testbench/drst_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Behavioural 64K x 1 memory device
module drst_dev_model #(
    parameter STEP_NS = 14000
) (
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire ref_n,
    input wire [7:0] addr,
    input wire din,
    output wire dout,
    output logic [6:0] ref_row
);
    logic mem [0:65535];
    logic [7:0] row_q;
    logic q_q = 1'b0;
    logic drv_q = 1'b0;
    realtime t_ref = 0;
    realtime t_next = 0;
    initial ref_row = 7'h00;
    // Address and strobe change in one step; latch once both have settled
    always @(negedge ras_n)
    begin
        #1;
        row_q = addr;
    end
    always @(negedge cas_n)
    begin
        if (!ras_n)
        begin
            if (!we_n)
                mem[{row_q, addr}] = din;
            else
            begin
                q_q = mem[{row_q, addr}];
                drv_q = 1'b1;
            end
        end
    end
    // Output held whatever the row strobe does
    always @(posedge cas_n) drv_q = 1'b0;
    // Floating output shows the inverse so a stale sample cannot match
    assign dout = drv_q ? q_q : ~q_q;
    always @(negedge ref_n)
    begin
        t_ref = $realtime;
        t_next = $realtime + STEP_NS;
    end
    // Open pin reads high: only a driven low counts
    always @(posedge ref_n)
    begin
        if (ras_n && $realtime - t_ref < 8000)
            ref_row = ref_row + 7'h01;
    end
    // Internal timer started by the refresh pin; 128 steps fit in 2 ms
    always #100
    begin
        if (ras_n && ref_n === 1'b0 && $realtime >= t_next)
        begin
            ref_row = ref_row + 7'h01;
            t_next = t_next + STEP_NS;
        end
    end
endmodule // drst_dev_model
`default_nettype wire
